/* include/pwm_time_base_pkg.sv */
// package: register map, field layout and types of the motor pwm time base
package pwm_time_base_pkg;

  // ---------------------------------------------------------------
  // register bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_WIDTH = 3;
  localparam int DATA_WIDTH = 16;
  localparam int COUNT_WIDTH = 15;
  localparam int DUTY_WIDTH = 16;
  localparam int POST_WIDTH = 4;
  localparam int PRE_WIDTH = 6;
  localparam int NUM_PAIRS = 3;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [ADDR_WIDTH-1:0] REG_CONTROL = 3'h0;
  localparam logic [ADDR_WIDTH-1:0] REG_COUNT = 3'h1;
  localparam logic [ADDR_WIDTH-1:0] REG_PERIOD = 3'h2;
  localparam logic [ADDR_WIDTH-1:0] REG_DUTY_ONE = 3'h3;
  localparam logic [ADDR_WIDTH-1:0] REG_DUTY_TWO = 3'h4;
  localparam logic [ADDR_WIDTH-1:0] REG_DUTY_THREE = 3'h5;
  localparam logic [ADDR_WIDTH-1:0] REG_EVENT = 3'h6;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int EVENT_FLAG_BIT = 0;
  localparam int DIR_BIT = 15;
  localparam logic [DATA_WIDTH-1:0] CONTROL_RESET = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0] PERIOD_RESET = 15'h0000;
  localparam logic [DUTY_WIDTH-1:0] DUTY_RESET = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 15'h0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 15'h0001;
  localparam logic [POST_WIDTH-1:0] POST_ZERO = 4'h0;
  localparam logic [PRE_WIDTH-1:0] PRE_ZERO = 6'h00;

  // prescaler terminal masks for 1:1, 1:4, 1:16, 1:64
  localparam logic [PRE_WIDTH-1:0] PRE_MASK_1 = 6'h00;
  localparam logic [PRE_WIDTH-1:0] PRE_MASK_4 = 6'h03;
  localparam logic [PRE_WIDTH-1:0] PRE_MASK_16 = 6'h0f;
  localparam logic [PRE_WIDTH-1:0] PRE_MASK_64 = 6'h3f;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FREE_RUN   = 2'h0,
    MODE_SINGLE     = 2'h1,
    MODE_UP_DOWN    = 2'h2,
    MODE_DOUBLE_UPD = 2'h3
  } count_mode_type;

  typedef enum logic [1:0] {
    DIV_1  = 2'h0,
    DIV_4  = 2'h1,
    DIV_16 = 2'h2,
    DIV_64 = 2'h3
  } input_divider_type;

  // control register, bit 15 down to bit 0
  typedef struct packed {
    logic              time_base_run;
    logic [6:0]        unused;
    logic [3:0]        match_divider_select;
    input_divider_type input_divider_select;
    count_mode_type    count_mode_select;
  } time_base_control_type;

  // register bus request
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } reg_request_type;

endpackage

/* rtl/motor_pwm_time_base_compare.sv */
// module: motor pwm time base with prescaler, postscaler and three duty compare pairs
`timescale 1ns/1ps

module motor_pwm_time_base_compare
  import pwm_time_base_pkg::*;
#(
  parameter int PAIRS = NUM_PAIRS
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire reg_request_type       bus_req,
  output logic [DATA_WIDTH-1:0]      rd_data,
  output logic [PAIRS-1:0]           pair_high_out,
  output logic [PAIRS-1:0]           pair_low_out,
  output logic                       time_base_event,
  output logic                       event_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  time_base_control_type    time_base_control;
  logic [COUNT_WIDTH-1:0]   time_base_count;
  logic                     count_down_flag;
  logic [COUNT_WIDTH-1:0]   period_buffer;
  logic [COUNT_WIDTH-1:0]   period_value;
  logic [DUTY_WIDTH-1:0]    duty_value [PAIRS];
  logic [PRE_WIDTH-1:0]     prescale;
  logic [POST_WIDTH-1:0]    postscale;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wr_control = bus_req.wr && (bus_req.addr == REG_CONTROL);
  wire wr_count   = bus_req.wr && (bus_req.addr == REG_COUNT);
  wire wr_period  = bus_req.wr && (bus_req.addr == REG_PERIOD);
  wire wr_event   = bus_req.wr && (bus_req.addr == REG_EVENT);
  wire clr_scalers = wr_control || wr_count;

  wire            running    = time_base_control.time_base_run;
  count_mode_type mode;
  assign mode = time_base_control.count_mode_select;
  wire            up_down    = (mode == MODE_UP_DOWN) || (mode == MODE_DOUBLE_UPD);

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic [PRE_WIDTH-1:0] pre_mask;
  assign pre_mask = (time_base_control.input_divider_select == DIV_1)  ? PRE_MASK_1 :
                    (time_base_control.input_divider_select == DIV_4)  ? PRE_MASK_4 :
                    (time_base_control.input_divider_select == DIV_16) ? PRE_MASK_16 :
                                                                        PRE_MASK_64;
  wire pre_done = ((prescale & pre_mask) == pre_mask);
  // second half of the prescale interval, used for half-count duty edges
  wire pre_half = |(prescale & (pre_mask ^ (pre_mask >> 1)));

  wire period_zero = (period_value == COUNT_ZERO);
  wire tick = running && pre_done && !period_zero;
  wire at_match = (time_base_count == period_value);
  wire at_zero = (time_base_count == COUNT_ZERO);

  // ---------------------------------------------------------------
  // counter next state
  // ---------------------------------------------------------------
  logic [COUNT_WIDTH-1:0] next_count;
  logic                   next_dir;
  logic                   raw_event;     // event subject to the postscaler
  logic                   direct_event;  // event that bypasses the postscaler
  logic                   load_period;
  logic                   single_stop;

  always_comb begin
    next_count   = time_base_count;
    next_dir     = count_down_flag;
    raw_event    = 1'b0;
    direct_event = 1'b0;
    load_period  = !running;
    single_stop  = 1'b0;
    if (tick) begin
      unique case (mode)
        MODE_FREE_RUN, MODE_SINGLE: begin
          next_dir = 1'b0;
          if (at_match) begin
            next_count  = COUNT_ZERO;
            load_period = 1'b1;
            if (mode == MODE_SINGLE) begin
              direct_event = 1'b1;
              single_stop  = 1'b1;
            end else begin
              raw_event = 1'b1;
            end
          end else begin
            next_count = time_base_count + COUNT_ONE;
          end
        end
        MODE_UP_DOWN, MODE_DOUBLE_UPD: begin
          if (!count_down_flag) begin
            if (at_match) begin
              next_dir   = 1'b1;
              next_count = time_base_count - COUNT_ONE;
              direct_event = (mode == MODE_DOUBLE_UPD);
            end else begin
              next_count = time_base_count + COUNT_ONE;
            end
          end else if (at_zero) begin
            next_dir    = 1'b0;
            next_count  = COUNT_ONE;
            raw_event    = (mode == MODE_UP_DOWN);
            direct_event = (mode == MODE_DOUBLE_UPD);
          end else begin
            next_count = time_base_count - COUNT_ONE;
          end
          if (at_zero) begin
            load_period = 1'b1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // postscaler
  // ---------------------------------------------------------------
  wire post_done = (postscale == time_base_control.match_divider_select);
  logic [POST_WIDTH-1:0] next_postscale;
  assign next_postscale = clr_scalers ? POST_ZERO :
                          !raw_event  ? postscale :
                          post_done   ? POST_ZERO :
                                        postscale + 4'h1;
  wire event_pulse = direct_event || (raw_event && post_done);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      time_base_control <= CONTROL_RESET;
    end else if (wr_control) begin
      time_base_control <= time_base_control_type'(bus_req.wdata);
    end else if (single_stop) begin
      time_base_control.time_base_run <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // prescaler and postscaler counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || clr_scalers) begin
      prescale <= PRE_ZERO;
    end else if (running) begin
      prescale <= pre_done ? PRE_ZERO : prescale + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      postscale <= POST_ZERO;
    end else begin
      postscale <= next_postscale;
    end
  end

  // ---------------------------------------------------------------
  // time base counter and direction
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      time_base_count <= COUNT_ZERO;
      count_down_flag <= 1'b0;
    end else if (wr_count) begin
      time_base_count <= bus_req.wdata[COUNT_WIDTH-1:0];
    end else begin
      time_base_count <= next_count;
      count_down_flag <= next_dir;
    end
  end

  // ---------------------------------------------------------------
  // period buffer and active period
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      period_buffer <= PERIOD_RESET;
    end else if (wr_period) begin
      period_buffer <= bus_req.wdata[COUNT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      period_value <= PERIOD_RESET;
    end else if (load_period) begin
      period_value <= period_buffer;
    end
  end

  // ---------------------------------------------------------------
  // duty registers
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : gen_duty
      wire wr_duty = bus_req.wr && (bus_req.addr == REG_DUTY_ONE + ADDR_WIDTH'(g));
      always_ff @(posedge clk) begin
        if (srst) begin
          duty_value[g] <= DUTY_RESET;
        end else if (wr_duty) begin
          duty_value[g] <= bus_req.wdata;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // duty compare outputs
  // ---------------------------------------------------------------
  // position in half counts: edge-aligned active from zero until duty,
  // center-aligned active from the duty match counting down to the duty match counting up
  logic [DUTY_WIDTH-1:0] half_position;
  assign half_position = {time_base_count, pre_half};
  wire [DUTY_WIDTH-1:0] period_wide = {1'b0, period_value};

  logic [PAIRS-1:0] next_high;
  generate
    for (g = 0; g < PAIRS; g++) begin : gen_cmp
      wire duty_zero = (duty_value[g] == DUTY_RESET);
      wire full_edge = (duty_value[g] > period_wide);
      wire full_center = (duty_value[g] == period_wide);
      wire below_duty = (half_position < duty_value[g]);
      // counting down, the output already turns on at the duty match itself
      wire at_duty = up_down && count_down_flag && (half_position == duty_value[g]);
      wire in_window = below_duty || at_duty;
      assign next_high[g] = duty_zero ? 1'b0 :
                            (up_down ? full_center : full_edge) ? 1'b1 :
                            in_window;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      pair_high_out <= '0;
      pair_low_out  <= '0;
    end else begin
      pair_high_out <= next_high;
      pair_low_out  <= ~next_high;
    end
  end

  // ---------------------------------------------------------------
  // event pulse and sticky flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      time_base_event <= 1'b0;
      event_flag      <= 1'b0;
    end else begin
      time_base_event <= event_pulse;
      // a new event wins over a clear in the same cycle
      event_flag <= event_pulse ||
                    (event_flag && !(wr_event && bus_req.wdata[EVENT_FLAG_BIT]));
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [DATA_WIDTH-1:0] read_mux;
  logic [DATA_WIDTH-1:0] duty_read;
  assign duty_read = (bus_req.addr == REG_DUTY_ONE)   ? duty_value[0] :
                     (bus_req.addr == REG_DUTY_TWO)   ? duty_value[1] :
                     (bus_req.addr == REG_DUTY_THREE) ? duty_value[2] : DUTY_RESET;
  assign read_mux =
    (bus_req.addr == REG_CONTROL) ? DATA_WIDTH'(time_base_control) :
    (bus_req.addr == REG_COUNT)   ? {count_down_flag, time_base_count} :
    (bus_req.addr == REG_PERIOD)  ? {1'b0, period_buffer} :
    (bus_req.addr == REG_EVENT)   ? {{(DATA_WIDTH-1){1'b0}}, event_flag} :
                                    duty_read;

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= bus_req.rd ? read_mux : '0;
    end
  end

endmodule

/* verification/pwm_time_base_props.sv */
// checker: port relations of the pwm time base
`timescale 1ns/1ps
module pwm_time_base_props
  import pwm_time_base_pkg::*;
#(
  parameter int PAIRS = NUM_PAIRS
) (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire reg_request_type       bus_req,
  input wire logic [DATA_WIDTH-1:0] rd_data,
  input wire logic [PAIRS-1:0]      pair_high_out,
  input wire logic [PAIRS-1:0]      pair_low_out,
  input wire logic                  time_base_event,
  input wire logic                  event_flag
);
  logic [14:0] per_buf;
  logic [15:0] duty_one;
  logic [7:0]  ctl_low;
  wire logic   clr_hit = bus_req.wr && bus_req.addr == REG_EVENT && bus_req.wdata[EVENT_FLAG_BIT];

  // shadow of the period, first duty and control low-byte registers as software writes them
  always_ff @(posedge clk) begin
    if (srst) begin
      per_buf <= '0;
      duty_one <= '0;
      ctl_low <= '0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == REG_PERIOD) per_buf <= bus_req.wdata[14:0];
      if (bus_req.addr == REG_DUTY_ONE) duty_one <= bus_req.wdata;
      if (bus_req.addr == REG_CONTROL) ctl_low <= bus_req.wdata[7:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_low_complement: assert property (!$past(srst) |-> pair_low_out == ~pair_high_out)
    else $error("low outputs differ from inverted high outputs");
  chk_event_one_clock: assert property (time_base_event |=> !time_base_event)
    else $error("event pulse longer than one clock");
  chk_flag_cause: assert property ($rose(event_flag) |-> time_base_event || $past(time_base_event))
    else $error("flag rose without an event");
  chk_flag_sticky: assert property (event_flag && !clr_hit |=> event_flag)
    else $error("flag dropped without a clear write");
  chk_duty_zero_off: assert property (duty_one == 16'h0000 && $past(duty_one) == 16'h0000 |-> !pair_high_out[0])
    else $error("output active with zero duty");
  chk_control_read: assert property (bus_req.rd && bus_req.addr == REG_CONTROL |=> rd_data[7:0] == ctl_low)
    else $error("control readback wrong");
  chk_period_read: assert property (bus_req.rd && bus_req.addr == REG_PERIOD |=> rd_data[14:0] == per_buf)
    else $error("period readback wrong");
  chk_duty_read: assert property (bus_req.rd && bus_req.addr == REG_DUTY_ONE |=> rd_data == duty_one)
    else $error("duty readback wrong");
  chk_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 3'h7 |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind motor_pwm_time_base_compare pwm_time_base_props #(.PAIRS(PAIRS)) props_u (
  .clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data), .pair_high_out(pair_high_out),
  .pair_low_out(pair_low_out), .time_base_event(time_base_event), .event_flag(event_flag));

/* verification/power_stage_model.sv */
// partner: power stage counting conduction and watching gate faults
`timescale 1ns/1ps
module power_stage_model (
  input  wire logic       clk,
  input  wire logic       clear,
  input  wire logic [2:0] gate_high,
  input  wire logic [2:0] gate_low,
  output logic [15:0]     on_cycles,
  output logic            shoot_through,
  output logic            lanes_differ
);
  always_ff @(posedge clk) begin
    if (clear) begin
      on_cycles <= 16'h0000;
      shoot_through <= 1'b0;
      lanes_differ <= 1'b0;
    end else begin
      on_cycles <= on_cycles + {15'h0000, gate_high[0] === 1'b1};
      if (|(gate_high & gate_low)) shoot_through <= 1'b1;
      if (gate_high !== {3{gate_high[0]}}) lanes_differ <= 1'b1;
    end
  end
endmodule

/* verification/tb_top.sv */
// testbench: table of pwm set-ups, then reset and corner cases
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import pwm_time_base_pkg::*;
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  div;
    logic [3:0]  post;
    logic [14:0] per;
    logic [15:0] duty;
    logic [15:0] high;
    logic [7:0]  ev;
  } row_type;
  logic            clk = 1'b0;
  logic            srst;
  logic            clear;
  reg_request_type bus_req;
  logic [15:0]     rd_data;
  logic [15:0]     on_cycles;
  logic [15:0]     v;
  logic [15:0]     w;
  logic [2:0]      high;
  logic [2:0]      low;
  logic            tb_event;
  logic            flag;
  logic            shoot;
  logic            differ;
  logic [7:0]      ev_count;
  int              failures;
  int              checks_done;
  int              len;
  // mode, divider, postscale, period, duty, high cycles and events in eight periods; no period of one
  row_type rows [10] = '{
    '{2'h0, 2'h0, 4'h0, 15'h4, 16'h0, 16'h0, 8'h8}, '{2'h0, 2'h0, 4'h1, 15'h4, 16'h4, 16'h10, 8'h4},
    '{2'h0, 2'h0, 4'h3, 15'h4, 16'h5, 16'h28, 8'h2}, '{2'h0, 2'h1, 4'h0, 15'h4, 16'h3, 16'h30, 8'h8},
    '{2'h0, 2'h2, 4'h0, 15'h2, 16'h2, 16'h80, 8'h8}, '{2'h0, 2'h3, 4'h0, 15'h2, 16'h2, 16'h200, 8'h8},
    '{2'h2, 2'h0, 4'h0, 15'h6, 16'h0, 16'h0, 8'h8}, '{2'h2, 2'h0, 4'h1, 15'h6, 16'h4, 16'h20, 8'h4},
    '{2'h2, 2'h0, 4'h0, 15'h6, 16'h6, 16'h60, 8'h8}, '{2'h3, 2'h0, 4'h3, 15'h6, 16'h4, 16'h20, 8'h10}};

  motor_pwm_time_base_compare dut_u (.clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .pair_high_out(high), .pair_low_out(low), .time_base_event(tb_event), .event_flag(flag));
  power_stage_model stage_u (.clk(clk), .clear(clear), .gate_high(high), .gate_low(low),
    .on_cycles(on_cycles), .shoot_through(shoot), .lanes_differ(differ));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (clear) begin
      ev_count <= 8'h00;
    end else if (tb_event === 1'b1) begin
      ev_count <= ev_count + 8'h01;
    end
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask

  task automatic clr();
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    bus_req = '0;
    srst = 1'b1;
    clear = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    clear <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      wr(REG_CONTROL, {1'b0, 7'h00, rows[i].post, rows[i].div, rows[i].mode});
      wr(REG_COUNT, 16'h0000);
      wr(REG_PERIOD, {1'b0, rows[i].per});
      for (int p = 0; p < 3; p++) wr(REG_DUTY_ONE + 3'(p), rows[i].duty);
      wr(REG_CONTROL, {1'b1, 7'h00, rows[i].post, rows[i].div, rows[i].mode});
      len = (rows[i].mode[1] ? 2 * rows[i].per : rows[i].per + 1) << (2 * rows[i].div);
      repeat (2 * len) @(posedge clk);
      clr();
      repeat (8 * len + 1) @(posedge clk);
      `CHK(on_cycles, rows[i].high)
      `CHK(ev_count, rows[i].ev)
      `CHK({shoot, differ}, 2'b00)
    end
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wr(3'h7, 16'hffff);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      `CHK(v, 16'h0000)
    end
    wr(REG_COUNT, 16'h0020);
    rd(REG_COUNT, v);
    `CHK(v, 16'h0020)
    wr(REG_PERIOD, 16'h0064);
    wr(REG_CONTROL, 16'h8000);
    repeat (10) @(posedge clk);
    wr(REG_CONTROL, 16'h0000);
    rd(REG_COUNT, v);
    repeat (5) @(posedge clk);
    wr(REG_CONTROL, 16'h0004);
    rd(REG_COUNT, w);
    `CHK(w, v)
    `CHK(v > 16'h0020, 1'b1)
    wr(REG_COUNT, 16'h0000);
    wr(REG_PERIOD, 16'h0004);
    wr(REG_EVENT, 16'h0001);
    clr();
    wr(REG_CONTROL, 16'h8031);
    repeat (30) @(posedge clk);
    rd(REG_CONTROL, v);
    `CHK(v, 16'h0031)
    rd(REG_COUNT, v);
    `CHK(v, 16'h0000)
    `CHK(ev_count, 8'h01)
    rd(REG_EVENT, v);
    `CHK(v[0], 1'b1)
    `CHK(flag, 1'b1)
    wr(REG_EVENT, 16'h0001);
    rd(REG_EVENT, v);
    `CHK(v[0], 1'b0)
    wr(REG_CONTROL, 16'h0000);
    wr(REG_PERIOD, 16'h0000);
    wr(REG_COUNT, 16'h0005);
    clr();
    wr(REG_CONTROL, 16'h8000);
    repeat (40) @(posedge clk);
    `CHK(ev_count, 8'h00)
    rd(REG_COUNT, v);
    `CHK(v, 16'h0005)
    wr(REG_CONTROL, 16'h0000);
    wr(REG_PERIOD, 16'h0064);
    wr(REG_CONTROL, 16'h8002);
    repeat (20) @(posedge clk);
    rd(REG_COUNT, v);
    `CHK(v[15], 1'b0)
    repeat (110) @(posedge clk);
    rd(REG_COUNT, v);
    `CHK(v[15], 1'b1)
    results();
  end
endmodule
